/* File: rtl/afec_apb_slave.sv */
// APB slave front end: turns the handshake and the address hit from afec_ctrl into one write strobe.
// Assumes a single APB master on pclk; answers with zero wait states.
`timescale 1ns/10ps
`include "afec_params.svh"
module afec_apb_slave (
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] rdata_in,
	input wire logic hit,
	output logic pready,
	output logic pslverr,
	output logic wr_stb,
	output logic [31:0] prdata
);
	// Unmapped addresses complete with an error so software sees the slip
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign wr_stb = psel & penable & pwrite & hit;
	assign prdata = (psel & ~pwrite & hit) ? rdata_in : 32'h0000_0000;
endmodule : afec_apb_slave

/* File: rtl/afec_cal_seq.sv */
// Offset calibration sequencer: sweeps the trim up then down.
// Assumes the amplifier output level is synchronous to pclk.
`timescale 1ns/10ps
`include "afec_params.svh"
module afec_cal_seq (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic amp_out,
	output logic busy,
	output logic done,
	output logic load,
	output logic [4:0] trim,
	output logic [4:0] result
);
	typedef struct packed {
		afec_pkg::afec_cal_state_t st;
		logic [15:0] wait_cnt;
		logic [4:0] trim;
		logic [4:0] first;
		logic [4:0] result;
		logic ref_lvl;
		logic done;
		logic load;
	} afec_seq_t;
	afec_seq_t s_r, s_nxt;
	function automatic logic [4:0] afec_avg(input logic [4:0] a, input logic [4:0] b);
		logic [5:0] sum;
		sum = {1'b0, a} + {1'b0, b};
		afec_avg = sum[5:1];
	endfunction : afec_avg
	wire settled = (s_r.wait_cnt == 16'h0000);
	always_comb begin
		s_nxt = s_r;
		s_nxt.load = 1'b0;
		if (!settled)
			s_nxt.wait_cnt = s_r.wait_cnt - 16'h0001;
		unique case (s_r.st)
			afec_pkg::afec_idle: begin
				if (start) begin
					s_nxt.st = afec_pkg::afec_up_start;
					s_nxt.trim = `AFEC_TRIM_MIN;
					s_nxt.done = 1'b0;
					s_nxt.load = 1'b1;
					s_nxt.wait_cnt = 16'(`AFEC_SETTLE_CYC);
				end
			end
			afec_pkg::afec_up_start, afec_pkg::afec_dn_start: begin
				if (settled) begin
					s_nxt.ref_lvl = amp_out;
					s_nxt.st = (s_r.st == afec_pkg::afec_up_start) ? afec_pkg::afec_up_step :
						afec_pkg::afec_dn_step;
					s_nxt.trim = (s_r.st == afec_pkg::afec_up_start) ? s_r.trim + 5'h01 :
						s_r.trim - 5'h01;
					s_nxt.load = 1'b1;
					s_nxt.wait_cnt = 16'(`AFEC_SETTLE_CYC);
				end
			end
			afec_pkg::afec_up_step: begin
				if (settled) begin
					// Saturate at the end code when no change is seen
					if (amp_out != s_r.ref_lvl || s_r.trim == `AFEC_TRIM_MAX) begin
						s_nxt.first = s_r.trim;
						s_nxt.st = afec_pkg::afec_dn_start;
						s_nxt.trim = `AFEC_TRIM_MAX;
					end else
						s_nxt.trim = s_r.trim + 5'h01;
					s_nxt.load = 1'b1;
					s_nxt.wait_cnt = 16'(`AFEC_SETTLE_CYC);
				end
			end
			afec_pkg::afec_dn_step: begin
				if (settled) begin
					if (amp_out != s_r.ref_lvl || s_r.trim == `AFEC_TRIM_MIN) begin
						s_nxt.result = afec_avg(s_r.first, s_r.trim);
						s_nxt.st = afec_pkg::afec_finish;
					end else begin
						s_nxt.trim = s_r.trim - 5'h01;
						s_nxt.load = 1'b1;
						s_nxt.wait_cnt = 16'(`AFEC_SETTLE_CYC);
					end
				end
			end
			afec_pkg::afec_finish: begin
				s_nxt.trim = s_r.result;
				s_nxt.load = 1'b1;
				s_nxt.done = 1'b1;
				s_nxt.st = afec_pkg::afec_idle;
			end
			default: s_nxt.st = afec_pkg::afec_idle;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end
	assign busy = (s_r.st != afec_pkg::afec_idle);
	assign done = s_r.done;
	assign load = s_r.load;
	assign trim = s_r.trim;
	assign result = s_r.result;
	final_load_a: assert property (@(posedge pclk) disable iff (!presetn)
		(s_r.st == afec_pkg::afec_finish) |=> (load && trim == $past(s_r.result) && done))
		else $error("final trim not loaded");
	settle_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
		(load && s_r.st != afec_pkg::afec_idle) |-> !$past(load))
		else $error("trim changed without settling");
endmodule : afec_cal_seq

/* File: rtl/afec_ctrl.sv */
// Analog front end control registers over APB, with calibration sequencer.
// Assumes the analog macros sample the outputs as static levels.
// How it works
// - Reference on bit powers generator
// - Reference select: internal, supply, floating
// - Unimplemented bits read zero, ignore writes
// - Reference trim register drives fine tune
// - Mode field: off-float, off-ground, enabled
// - Code is high byte plus low bits
// - Bit 7 selects calibration mode
// - Bit 6 picks input or converter
// - Bit 5 enables amplifier, reset off
// - Bits 4..0 drive offset trim
// - Bit 3 closes ground node switch
// - Bits 2..0 connect gain taps
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "afec_params.svh"
module afec_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic amp_output_pin,
	output logic ref_gen_on,
	output logic ref_float,
	output logic [7:0] ref_fine_trim,
	output logic [1:0] dac_ref_select,
	output logic dac_ref_internal,
	output logic dac_ref_supply,
	output logic dac_ref_float,
	output logic dac_enable,
	output logic dac_out_ground,
	output logic dac_out_float,
	output logic [9:0] dac_code,
	output logic amp_cal_mode,
	output logic amp_cal_ref_select,
	output logic amp_on,
	output logic [4:0] amp_offset_trim,
	output logic gain_ground_switch,
	output logic [2:0] gain_tap_switch
);
	afec_pkg::afec_regs_t r_r, r_nxt;
	logic hit;
	logic wr_stb;
	logic [7:0] rd_byte;
	logic [31:0] rd_word;
	logic cal_busy, cal_done, cal_load;
	logic [4:0] cal_trim, cal_result;
	logic cal_start;
	logic [7:0] wbyte;
	assign wbyte = pstrb[0] ? pwdata[7:0] : 8'h00;
	always_comb begin
		hit = 1'b1;
		rd_byte = 8'h00;
		unique case (paddr)
			`AFEC_OFS_REF_CTRL: rd_byte = r_r.ref_control;
			`AFEC_OFS_REF_TRIM: rd_byte = r_r.ref_trim;
			`AFEC_OFS_DAC_MODE: rd_byte = r_r.dac_mode_control;
			`AFEC_OFS_DAC_HIGH: rd_byte = r_r.dac_code_high;
			`AFEC_OFS_DAC_LOW: rd_byte = r_r.dac_code_low;
			`AFEC_OFS_AMP_CTRL: rd_byte = r_r.amp_control;
			`AFEC_OFS_GAIN_SW: rd_byte = r_r.gain_switch_control;
			`AFEC_OFS_CAL_CTRL: rd_byte = 8'h00;
			`AFEC_OFS_CAL_STAT: rd_byte = {1'b0, cal_busy, cal_done, cal_result};
			default: hit = 1'b0;
		endcase
	end
	assign rd_word = {24'h000000, rd_byte};
	afec_apb_slave u_apb (
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.rdata_in(rd_word),
		.hit(hit),
		.pready(pready),
		.pslverr(pslverr),
		.wr_stb(wr_stb),
		.prdata(prdata)
	);
	// Sweep only makes sense in cancellation mode against the converter
	assign cal_start = wr_stb && pstrb[0] && paddr == `AFEC_OFS_CAL_CTRL && pwdata[0] &&
		r_r.amp_control[`AFEC_BIT_CAL_MODE] && r_r.amp_control[`AFEC_BIT_CAL_REF] && !cal_busy;
	afec_cal_seq u_seq (
		.pclk(pclk),
		.presetn(presetn),
		.start(cal_start),
		.amp_out(amp_output_pin),
		.busy(cal_busy),
		.done(cal_done),
		.load(cal_load),
		.trim(cal_trim),
		.result(cal_result)
	);
	always_comb begin
		r_nxt = r_r;
		if (wr_stb && pstrb[0]) begin
			unique case (paddr)
				`AFEC_OFS_REF_CTRL: r_nxt.ref_control = wbyte & `AFEC_MASK_REF_CTRL;
				`AFEC_OFS_REF_TRIM: r_nxt.ref_trim = wbyte;
				`AFEC_OFS_DAC_MODE: r_nxt.dac_mode_control = wbyte & `AFEC_MASK_DAC_MODE;
				`AFEC_OFS_DAC_HIGH: begin
					r_nxt.dac_code_high = wbyte;
					// Latched here so a low-then-high pair never shows a torn code
					r_nxt.dac_code = {wbyte, r_r.dac_code_low[7:6]};
				end
				`AFEC_OFS_DAC_LOW: r_nxt.dac_code_low = wbyte & `AFEC_MASK_DAC_LOW;
				`AFEC_OFS_AMP_CTRL: r_nxt.amp_control = wbyte;
				`AFEC_OFS_GAIN_SW: r_nxt.gain_switch_control = wbyte & `AFEC_MASK_GAIN_SW;
				default: r_nxt = r_r;
			endcase
		end
		// Sequencer rewrites the trim field on each of its load cycles; it wins over a software write in that cycle
		if (cal_load)
			r_nxt.amp_control[4:0] = cal_trim;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			r_r <= '0;
		else
			r_r <= r_nxt;
	end
	assign ref_gen_on = r_r.ref_control[`AFEC_BIT_REF_ON];
	assign ref_float = ~r_r.ref_control[`AFEC_BIT_REF_ON];
	assign ref_fine_trim = r_r.ref_trim;
	assign dac_ref_select = r_r.ref_control[1:0];
	assign dac_ref_internal = ~r_r.ref_control[1];
	assign dac_ref_supply = (r_r.ref_control[1:0] == 2'(afec_pkg::afec_ref_supply));
	assign dac_ref_float = (r_r.ref_control[1:0] == 2'(afec_pkg::afec_ref_float));
	assign dac_enable = r_r.dac_mode_control[0];
	assign dac_out_ground = (r_r.dac_mode_control[1:0] == 2'h2);
	assign dac_out_float = (r_r.dac_mode_control[1:0] == 2'h0);
	assign dac_code = r_r.dac_code;
	assign amp_cal_mode = r_r.amp_control[`AFEC_BIT_CAL_MODE];
	assign amp_cal_ref_select = r_r.amp_control[`AFEC_BIT_CAL_REF];
	assign amp_on = r_r.amp_control[`AFEC_BIT_AMP_ON];
	assign amp_offset_trim = r_r.amp_control[4:0];
	assign gain_ground_switch = r_r.gain_switch_control[`AFEC_BIT_GND_SW];
	assign gain_tap_switch = r_r.gain_switch_control[2:0];
	sequence high_write_s;
		wr_stb && pstrb[0] && paddr == `AFEC_OFS_DAC_HIGH;
	endsequence
	dac_atomic_a: assert property (@(posedge pclk) disable iff (!presetn)
		high_write_s |=> dac_code == {$past(pwdata[7:0]), $past(r_r.dac_code_low[7:6])})
		else $error("code not applied on high write");
	dac_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr_stb && paddr == `AFEC_OFS_DAC_HIGH) |=> $stable(dac_code))
		else $error("code moved without high write");
	unimpl_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		(r_r.ref_control & ~`AFEC_MASK_REF_CTRL) == 8'h00 &&
		(r_r.gain_switch_control & ~`AFEC_MASK_GAIN_SW) == 8'h00 &&
		(r_r.dac_mode_control & ~`AFEC_MASK_DAC_MODE) == 8'h00 &&
		(r_r.dac_code_low & ~`AFEC_MASK_DAC_LOW) == 8'h00)
		else $error("unimplemented bit set");
	ref_on_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_stb && pstrb[0] && paddr == `AFEC_OFS_REF_CTRL) |=> ref_gen_on == $past(pwdata[4]))
		else $error("reference enable wrong");
	dac_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
		dac_enable |-> !dac_out_ground && !dac_out_float)
		else $error("converter mode decode wrong");
	ref_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
		$onehot({dac_ref_internal, dac_ref_supply, dac_ref_float}))
		else $error("reference select decode wrong");
	cal_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		cal_start |-> amp_cal_mode && amp_cal_ref_select)
		else $error("sweep started outside cancellation");
	gain_sw_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_stb && pstrb[0] && paddr == `AFEC_OFS_GAIN_SW) |=>
		{gain_ground_switch, gain_tap_switch} == $past(pwdata[3:0]))
		else $error("gain switches wrong");
endmodule : afec_ctrl

/* File: rtl/afec_params.svh */
// Constants for the analog front end control block.
// Assumes inclusion by every module file of the block.
`ifndef AFEC_PARAMS_SVH
`define AFEC_PARAMS_SVH
`define AFEC_OFS_REF_CTRL 12'h000
`define AFEC_OFS_REF_TRIM 12'h004
`define AFEC_OFS_DAC_MODE 12'h008
`define AFEC_OFS_DAC_HIGH 12'h00c
`define AFEC_OFS_DAC_LOW 12'h010
`define AFEC_OFS_AMP_CTRL 12'h014
`define AFEC_OFS_GAIN_SW 12'h018
`define AFEC_OFS_CAL_CTRL 12'h01c
`define AFEC_OFS_CAL_STAT 12'h020
`define AFEC_MASK_REF_CTRL 8'h13
`define AFEC_MASK_DAC_MODE 8'h03
`define AFEC_MASK_DAC_LOW 8'hc0
`define AFEC_MASK_GAIN_SW 8'h0f
`define AFEC_BIT_REF_ON 4
`define AFEC_BIT_CAL_MODE 7
`define AFEC_BIT_CAL_REF 6
`define AFEC_BIT_AMP_ON 5
`define AFEC_BIT_GND_SW 3
`define AFEC_REF_TRIM_NOM 8'h80
`define AFEC_TRIM_MIN 5'h00
`define AFEC_TRIM_MAX 5'h1f
`define AFEC_SETTLE_NS 2000
`define AFEC_CLK_NS 25
`define AFEC_SETTLE_CYC ((`AFEC_SETTLE_NS + `AFEC_CLK_NS - 1) / `AFEC_CLK_NS)
`endif

/* File: rtl/afec_pkg.sv */
// Types for the analog front end control block.
// Assumes afec_params.svh for all numeric constants.
package afec_pkg;
	typedef enum logic [1:0] {afec_ref_int, afec_ref_int_b, afec_ref_supply, afec_ref_float} afec_ref_t;
	typedef enum logic [2:0] {afec_idle, afec_up_start, afec_up_step, afec_dn_start, afec_dn_step,
		afec_finish} afec_cal_state_t;
	typedef struct packed {
		logic [7:0] ref_control;
		logic [7:0] ref_trim;
		logic [7:0] dac_mode_control;
		logic [7:0] dac_code_high;
		logic [7:0] dac_code_low;
		logic [7:0] amp_control;
		logic [7:0] gain_switch_control;
		logic [9:0] dac_code;
	} afec_regs_t;
endpackage : afec_pkg

/* File: tb/tb_top.sv */
// Testbench for the analog front end control block: APB tasks, register and sweep tests.
// Assumes afec_ctrl answers APB with zero wait states and the sweep settles 80 cycles a step.
`timescale 1ns/10ps
`include "afec_params.svh"
module tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic amp_pin = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, ref_gen_on, ref_float, dac_ref_internal, dac_ref_supply;
	logic dac_ref_float, dac_enable, dac_out_ground, dac_out_float;
	logic amp_cal_mode, amp_cal_ref_select, amp_on, gain_ground_switch;
	logic [7:0] ref_fine_trim;
	logic [1:0] dac_ref_select;
	logic [9:0] dac_code;
	logic [4:0] amp_offset_trim;
	logic [2:0] gain_tap_switch;
	int failures = 0;
	int n_checks = 0;
	logic [31:0] rd;
	logic err;
	logic [11:0] ofs [7] = '{`AFEC_OFS_REF_CTRL, `AFEC_OFS_REF_TRIM, `AFEC_OFS_DAC_MODE,
		`AFEC_OFS_DAC_HIGH, `AFEC_OFS_DAC_LOW, `AFEC_OFS_AMP_CTRL, `AFEC_OFS_GAIN_SW};
	logic [7:0] msk [7] = '{8'h13, 8'hff, 8'h03, 8'hff, 8'hc0, 8'hff, 8'h0f};

	always #12.5 pclk = ~pclk;

	// Amplifier output flips once the trim reaches 9; the sum 9 + 8 is odd on purpose
	always @(posedge pclk) begin
		amp_pin <= (amp_offset_trim >= 5'h09);
	end

	afec_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .amp_output_pin(amp_pin),
		.ref_gen_on(ref_gen_on), .ref_float(ref_float), .ref_fine_trim(ref_fine_trim),
		.dac_ref_select(dac_ref_select), .dac_ref_internal(dac_ref_internal),
		.dac_ref_supply(dac_ref_supply), .dac_ref_float(dac_ref_float),
		.dac_enable(dac_enable), .dac_out_ground(dac_out_ground),
		.dac_out_float(dac_out_float), .dac_code(dac_code), .amp_cal_mode(amp_cal_mode),
		.amp_cal_ref_select(amp_cal_ref_select), .amp_on(amp_on),
		.amp_offset_trim(amp_offset_trim), .gain_ground_switch(gain_ground_switch),
		.gain_tap_switch(gain_tap_switch));

	task automatic close_out;
		if (failures == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; read data and error are taken at the edge that sees pready
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		forever begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		xfer(1'b1, a, {24'h0, d});
	endtask : wr

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rd_chk

	// Outputs move at the access edge; sample one edge later
	task automatic settle;
		@(posedge pclk);
		#1;
	endtask : settle

	initial begin
		#1000000;
		failures++;
		close_out();
	end

	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk({ref_gen_on, ref_float, dac_ref_internal, dac_out_float, amp_on}, 32'h0e);
		for (int i = 0; i < 7; i++) begin
			rd_chk(ofs[i], 32'h0);
			wr(ofs[i], 8'hff);
			rd_chk(ofs[i], {24'h0, msk[i]});
			wr(ofs[i], 8'h00);
		end
		for (int i = 0; i < 4; i++) begin
			wr(`AFEC_OFS_REF_CTRL, 8'(i) | ((i[0]) ? 8'h10 : 8'h00));
			wr(`AFEC_OFS_DAC_MODE, 8'(i));
			settle();
			chk({ref_gen_on, ref_float}, i[0] ? 32'h2 : 32'h1);
			chk(dac_ref_select, i);
			chk({dac_ref_internal, dac_ref_supply, dac_ref_float}, (i < 2) ? 4 : (i == 2) ? 2 : 1);
			chk({dac_enable, dac_out_ground, dac_out_float}, i[0] ? 4 : (i == 2) ? 2 : 1);
		end
		for (int i = 0; i < 4; i++) begin
			wr(`AFEC_OFS_GAIN_SW, 8'(1 << i));
			settle();
			chk({gain_ground_switch, gain_tap_switch}, 32'(1 << i));
		end
		wr(`AFEC_OFS_REF_TRIM, `AFEC_REF_TRIM_NOM);
		settle();
		chk(ref_fine_trim, 32'h80);
		wr(`AFEC_OFS_DAC_LOW, 8'hc0);
		settle();
		chk(dac_code, 32'h0);
		wr(`AFEC_OFS_DAC_HIGH, 8'ha5);
		settle();
		chk(dac_code, 32'h297);
		wr(`AFEC_OFS_DAC_LOW, 8'h40);
		wr(`AFEC_OFS_DAC_HIGH, 8'h01);
		settle();
		chk(dac_code, 32'h005);
		wr(`AFEC_OFS_AMP_CTRL, 8'h55);
		settle();
		chk({amp_cal_mode, amp_cal_ref_select, amp_on, amp_offset_trim}, 32'h55);
		wr(`AFEC_OFS_AMP_CTRL, 8'ha5);
		settle();
		chk({amp_cal_mode, amp_cal_ref_select, amp_on, amp_offset_trim}, 32'ha5);
		xfer(1'b1, 12'h040, 32'hff);
		chk(err, 1'b1);
		xfer(1'b0, 12'h040, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		// Start without the reference select set must be ignored
		wr(`AFEC_OFS_CAL_CTRL, 8'h01);
		settle();
		rd_chk(`AFEC_OFS_CAL_STAT, 32'h0);
		rd_chk(`AFEC_OFS_AMP_CTRL, 32'ha5);
		wr(`AFEC_OFS_AMP_CTRL, 8'hc5);
		wr(`AFEC_OFS_CAL_CTRL, 8'h01);
		repeat (40) @(posedge pclk);
		#1;
		chk(amp_offset_trim, `AFEC_TRIM_MIN);
		for (int n = 0; n < 2000; n++) begin
			xfer(1'b0, `AFEC_OFS_CAL_STAT, 32'h0);
			if (rd[5] === 1'b1) break;
		end
		chk(rd, 32'h28);
		rd_chk(`AFEC_OFS_AMP_CTRL, 32'hc8);
		settle();
		chk(amp_offset_trim, 32'h08);
		// Mid-run reset must clear settings left by the sweep
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk({amp_cal_mode, amp_cal_ref_select, amp_on, amp_offset_trim}, 32'h0);
		chk(ref_fine_trim, 32'h0);
		chk(dac_code, 32'h0);
		rd_chk(`AFEC_OFS_CAL_STAT, 32'h0);
		close_out();
	end
endmodule : tb_top
